/* rtl/seb_defs.svh */
// Shared constants for both ends of the two-wire serial memory bus
`ifndef SEB_DEFS_SVH
`define SEB_DEFS_SVH
// System clock rate in MHz
`define SEB_CLK_MHZ 100
// Initialisation interval after power-up, ns
`define SEB_INIT_NS 5000
// Least time rounds up to whole cycles
`define SEB_INIT_CYC ((`SEB_INIT_NS * `SEB_CLK_MHZ + 999) / 1000)
// Bus clock rate made by the master, kHz
`define SEB_SCL_KHZ 400
// Quarter of one bus clock period in system cycles, rounded up
`define SEB_QUARTER_CYC ((`SEB_CLK_MHZ * 1000 + 4 * `SEB_SCL_KHZ - 1) / (4 * `SEB_SCL_KHZ))
// Device select code; value is arbitrary
`define SEB_DEV_ID 7'h50
// Clock index of the acknowledge slot (ninth clock of a byte)
`define SEB_ACK_SLOT 4'h8
`endif

/* rtl/seb_pkg.sv */
// Types shared by both ends of the serial memory bus
package seb_pkg;

  // Device protocol states
  typedef enum logic [2:0] {ST_INIT, ST_IDLE, ST_DEVA, ST_WORD, ST_WDATA, ST_RDATA, ST_SKIP} seb_dev_state_e;

  // Master sequencer states
  typedef enum logic [1:0] {M_WAIT, M_IDLE, M_RUN} seb_mst_state_e;

  // Master commands
  typedef enum logic [2:0] {OP_WRITE, OP_READ, OP_READ_CUR, OP_BUS_RESET, OP_CANCEL} seb_op_e;

  // Bus symbols a command is built from
  typedef enum logic [2:0] {SYM_START, SYM_STOP, SYM_DEVW, SYM_DEVR, SYM_WORD, SYM_DATA, SYM_READ,
                            SYM_DUMMY} seb_sym_e;

  // Device state on the system clock
  typedef struct packed {
    seb_dev_state_e st;
    logic [3:0]     cnt;
    logic [7:0]     sh;
    logic [7:0]     rd_sh;
    logic [7:0]     word;
    logic           got_data;
    logic           drive_low;
    logic [15:0]    init_cnt;
    logic [2:0]     scl_r;
    logic [2:0]     sda_r;
    logic [2:0]     tog_r;
    logic           scl_st;
    logic           sda_st;
    logic           rd_strobe;
    logic           wr_valid;
    logic           commit;
    logic [7:0]     wr_addr;
    logic [7:0]     wr_data;
  } seb_dev_s;

  // Device state on the bus clock
  typedef struct packed {
    logic cap_bit;
    logic cap_tog;
  } seb_lnk_s;

  // Master state
  typedef struct packed {
    seb_mst_state_e st;
    seb_op_e        op;
    logic [2:0]     step;
    logic [3:0]     bitn;
    logic [1:0]     q;
    logic [15:0]    div;
    logic [15:0]    wait_cnt;
    logic           scl;
    logic           sda_rel;
    logic [7:0]     rx;
    logic [7:0]     addr;
    logic [7:0]     data;
    logic [7:0]     rd_data;
    logic           ack_bad;
    logic           abort;
    logic           addr_unknown;
    logic           done;
    logic           nack;
    logic [2:0]     sda_r;
    logic           sda_st;
  } seb_mst_s;

endpackage : seb_pkg

/* rtl/seb_bus_if.sv */
// Two-wire bus between master and memory device, open-drain data line
`timescale 1ns/1ps
interface seb_bus_if;
  logic scl;
  logic sda_m_o;
  logic sda_m_oe;
  logic sda_s_o;
  logic sda_s_oe;
  logic sda;

  // Wired-AND with pull-up: any enabled low driver wins
  assign sda = ~((sda_m_oe & ~sda_m_o) | (sda_s_oe & ~sda_s_o));

  modport mst (output scl, output sda_m_o, output sda_m_oe, input sda);
  modport dev (input scl, input sda, output sda_s_o, output sda_s_oe);
endinterface : seb_bus_if

/* rtl/seb_slave.sv */
// Memory device end: bus slave control with power-up initialisation
`timescale 1ns/1ps
`include "seb_defs.svh"
module seb_slave
  import seb_pkg::*;
#(
  parameter int         INIT_CYCLES = `SEB_INIT_CYC,
  parameter logic [6:0] DEV_ID      = `SEB_DEV_ID
)
(
  // System clock and power-up reset
  input  wire logic       clk_sys_i,
  input  wire logic       sys_rst_i,
  // Bus pins; the bus clock also clocks the capture stage
  seb_bus_if.dev          bus,
  // Power-on-clear model
  input  wire logic       poc_i,
  input  wire logic       poc_fail_i,
  // Memory array side
  input  wire logic [7:0] rd_data_i,
  output logic [7:0]      rd_addr_o,
  output logic            rd_strobe_o,
  output logic            wr_byte_valid_o,
  output logic [7:0]      wr_addr_o,
  output logic [7:0]      wr_data_o,
  output logic            wr_commit_o,
  // Status
  output logic            standby_o,
  output logic            init_done_o
);

  localparam seb_dev_s DEV_RST = '{st: ST_INIT, scl_r: 3'h7, sda_r: 3'h7, scl_st: 1'b1, sda_st: 1'b1,
                                   default: '0};

  seb_dev_s r;
  seb_dev_s next_r;
  seb_lnk_s l;
  seb_lnk_s next_l;

  logic start_ev;
  logic stop_ev;
  logic fall_ev;
  logic rise_ev;
  logic addr_hit;

  // Bus clock domain: capture data on each rising edge, toggle marks it
  always_comb
  begin
    next_l         = l;
    next_l.cap_bit = bus.sda;
    next_l.cap_tog = ~l.cap_tog;
  end

  always_ff @(posedge bus.scl or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      l <= '0;
    end
    else
    begin
      l <= next_l;
    end
  end

  // Device select matches the received address byte
  assign addr_hit = (r.sh[7:1] == DEV_ID);

  // System domain: pin filters, event decode and protocol
  always_comb
  begin
    next_r           = r;
    next_r.rd_strobe = 1'b0;
    next_r.wr_valid  = 1'b0;
    next_r.commit    = 1'b0;
    // Three-stage pin filter; a level counts once stages two and three agree
    next_r.scl_r = {r.scl_r[1:0], bus.scl};
    next_r.sda_r = {r.sda_r[1:0], bus.sda};
    next_r.tog_r = {r.tog_r[1:0], l.cap_tog};
    if (r.scl_r[1] == r.scl_r[2])
    begin
      next_r.scl_st = r.scl_r[2];
    end
    if (r.sda_r[1] == r.sda_r[2])
    begin
      next_r.sda_st = r.sda_r[2];
    end
    // Start and stop need the clock high on both sides of the data edge
    start_ev = r.scl_st & next_r.scl_st & r.sda_st & ~next_r.sda_st;
    stop_ev  = r.scl_st & next_r.scl_st & ~r.sda_st & next_r.sda_st;
    fall_ev  = r.scl_st & ~next_r.scl_st;
    // Captured bit is stable well before its toggle is seen here
    rise_ev  = r.tog_r[1] ^ r.tog_r[2];

    if (poc_i && !poc_fail_i)
    begin
      // Power-on-clear restarts the initialisation interval
      next_r.st        = ST_INIT;
      next_r.init_cnt  = '0;
      next_r.drive_low = 1'b0;
    end
    else if (r.st == ST_INIT)
    begin
      // Receiver disabled: no start, stop or bit is looked at
      next_r.drive_low = 1'b0;
      if (r.init_cnt == 16'(INIT_CYCLES - 1))
      begin
        next_r.st       = ST_IDLE;
        next_r.cnt      = '0;
        next_r.got_data = 1'b0;
      end
      else
      begin
        next_r.init_cnt = r.init_cnt + 16'h0001;
      end
    end
    // A failed clear falls through here with the old command intact
    else if (start_ev)
    begin
      // Start cancels whatever was shifting in; address counter untouched
      next_r.st        = ST_DEVA;
      next_r.cnt       = '0;
      next_r.got_data  = 1'b0;
      next_r.drive_low = 1'b0;
    end
    else if (stop_ev)
    begin
      // Only the stop's own clock may follow the last data acknowledge
      if (r.st == ST_WDATA && r.got_data && r.cnt <= 4'h1)
      begin
        next_r.commit = 1'b1;
      end
      next_r.st        = ST_IDLE;
      next_r.cnt       = '0;
      next_r.got_data  = 1'b0;
      next_r.drive_low = 1'b0;
    end
    else
    begin
      // Rising bus clock: shift a bit or close the acknowledge slot
      if (rise_ev && r.st != ST_IDLE && r.st != ST_SKIP)
      begin
        if (r.cnt != `SEB_ACK_SLOT)
        begin
          next_r.sh  = {r.sh[6:0], l.cap_bit};
          next_r.cnt = r.cnt + 4'h1;
        end
        else
        begin
          next_r.cnt = '0;
          unique case (r.st)
            ST_DEVA:
            begin
              if (!addr_hit)
              begin
                next_r.st = ST_SKIP;
              end
              else if (r.sh[0])
              begin
                next_r.st        = ST_RDATA;
                next_r.rd_sh     = rd_data_i;
                next_r.rd_strobe = 1'b1;
                next_r.word      = r.word + 8'h01;
              end
              else
              begin
                next_r.st = ST_WORD;
              end
            end
            ST_WORD:
            begin
              // Counter reloads only on a whole acknowledged word address
              next_r.word = r.sh;
              next_r.st   = ST_WDATA;
            end
            ST_WDATA:
            begin
              next_r.got_data = 1'b1;
              next_r.wr_valid = 1'b1;
              next_r.wr_addr  = r.word;
              next_r.wr_data  = r.sh;
              next_r.word     = r.word + 8'h01;
            end
            ST_RDATA:
            begin
              // Master acknowledge asks for the next byte; released line ends it
              if (!l.cap_bit)
              begin
                next_r.rd_sh     = rd_data_i;
                next_r.rd_strobe = 1'b1;
                next_r.word      = r.word + 8'h01;
              end
              else
              begin
                next_r.st = ST_SKIP;
              end
            end
            default:
            begin
              next_r.st = ST_SKIP;
            end
          endcase
        end
      end
      // Falling bus clock: set up the line for the coming clock
      if (fall_ev)
      begin
        if (r.cnt == `SEB_ACK_SLOT)
        begin
          next_r.drive_low = (r.st == ST_DEVA && addr_hit) || r.st == ST_WORD || r.st == ST_WDATA;
        end
        else
        begin
          // Dummy clocks with a released line walk a read out to its end
          next_r.drive_low = (r.st == ST_RDATA) && !r.rd_sh[~r.cnt[2:0]];
        end
      end
    end
  end

  always_ff @(posedge clk_sys_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      r <= DEV_RST;
    end
    else
    begin
      r <= next_r;
    end
  end

  // Open-drain data line: only ever pulls low
  assign bus.sda_s_o     = 1'b0;
  assign bus.sda_s_oe    = r.drive_low;
  assign rd_addr_o       = r.word;
  assign rd_strobe_o     = r.rd_strobe;
  assign wr_byte_valid_o = r.wr_valid;
  assign wr_addr_o       = r.wr_addr;
  assign wr_data_o       = r.wr_data;
  assign wr_commit_o     = r.commit;
  assign standby_o       = (r.st == ST_IDLE);
  assign init_done_o     = (r.st != ST_INIT);

endmodule : seb_slave

/* rtl/seb_master.sv */
// Bus master end: makes the bus clock and runs command sequences
`timescale 1ns/1ps
`include "seb_defs.svh"
module seb_master
  import seb_pkg::*;
#(
  parameter int         QUARTER        = `SEB_QUARTER_CYC,
  parameter int         INIT_CYCLES    = `SEB_INIT_CYC,
  parameter bit         RESET_AT_START = 1'b1,
  parameter logic [6:0] DEV_ID         = `SEB_DEV_ID
)
(
  // System clock and reset
  input  wire logic       clk_sys_i,
  input  wire logic       sys_rst_i,
  // Bus pins
  seb_bus_if.mst          bus,
  // Command request
  input  wire logic       cmd_valid_i,
  input  seb_op_e         cmd_op_i,
  input  wire logic [7:0] cmd_addr_i,
  input  wire logic [7:0] cmd_data_i,
  output logic            cmd_ready_o,
  // Command answer
  output logic            done_o,
  output logic            nack_o,
  output logic [7:0]      rd_data_o
);

  localparam seb_mst_s MST_RST = '{st: M_WAIT, op: OP_WRITE, scl: 1'b1, sda_rel: 1'b1, addr_unknown: 1'b1,
                                   sda_r: 3'h7, sda_st: 1'b1, default: '0};

  seb_mst_s r;
  seb_mst_s next_r;
  seb_sym_e sym;
  logic     tick;
  logic [7:0] txb;

  // Symbol program of each command; the stop always comes last
  function automatic seb_sym_e prog(input seb_op_e op, input logic [2:0] step);
    logic [0:7][2:0] p;
    p = {8{SYM_STOP}};
    unique case (op)
      OP_WRITE:     p[0:3] = {SYM_START, SYM_DEVW, SYM_WORD, SYM_DATA};
      OP_READ:      p[0:5] = {SYM_START, SYM_DEVW, SYM_WORD, SYM_START, SYM_DEVR, SYM_READ};
      OP_READ_CUR:  p[0:2] = {SYM_START, SYM_DEVR, SYM_READ};
      // Start, nine released clocks, start again before any clocking
      OP_BUS_RESET: p[0:2] = {SYM_START, SYM_DUMMY, SYM_START};
      OP_CANCEL:    p[0:3] = {SYM_START, SYM_DEVW, SYM_WORD, SYM_START};
      default:      p[0]   = SYM_STOP;
    endcase
    return seb_sym_e'(p[step]);
  endfunction : prog

  always_comb
  begin
    next_r      = r;
    next_r.done = 1'b0;
    next_r.sda_r = {r.sda_r[1:0], bus.sda};
    if (r.sda_r[1] == r.sda_r[2])
    begin
      next_r.sda_st = r.sda_r[2];
    end
    tick = (r.div == 16'(QUARTER - 1));
    sym  = r.abort ? SYM_STOP : prog(r.op, r.step);
    txb  = (sym == SYM_DEVW) ? {DEV_ID, 1'b0} : (sym == SYM_DEVR) ? {DEV_ID, 1'b1} :
           (sym == SYM_WORD) ? r.addr : r.data;
    unique case (r.st)
      M_WAIT:
      begin
        // No command until the device's initialisation has run out
        if (r.wait_cnt == 16'(INIT_CYCLES - 1))
        begin
          // Power-up clear cannot be trusted, so resynchronise first
          next_r.st   = RESET_AT_START ? M_RUN : M_IDLE;
          next_r.op   = OP_BUS_RESET;
          next_r.step = '0;
          next_r.bitn = '0;
          next_r.q    = '0;
          next_r.div  = '0;
        end
        else
        begin
          next_r.wait_cnt = r.wait_cnt + 16'h0001;
        end
      end
      M_IDLE:
      begin
        if (cmd_valid_i)
        begin
          // Address unknown after cancel or reset: reload it instead
          next_r.op    = (cmd_op_i == OP_READ_CUR && r.addr_unknown) ? OP_READ : cmd_op_i;
          next_r.addr  = cmd_addr_i;
          next_r.data  = cmd_data_i;
          next_r.st    = M_RUN;
          next_r.step  = '0;
          next_r.bitn  = '0;
          next_r.q     = '0;
          next_r.div   = '0;
          next_r.abort = 1'b0;
        end
      end
      M_RUN:
      begin
        next_r.div = tick ? '0 : r.div + 16'h0001;
        if (tick)
        begin
          next_r.q = r.q + 2'h1;
          unique case (sym)
            SYM_START:
            begin
              // Line is free here: the device let go at the last falling clock
              unique case (r.q)
                2'h0: next_r.sda_rel = 1'b1;
                2'h1: next_r.scl     = 1'b1;
                2'h2: next_r.sda_rel = 1'b0;
                default:
                begin
                  next_r.scl  = 1'b0;
                  next_r.step = r.step + 3'h1;
                end
              endcase
            end
            SYM_STOP:
            begin
              unique case (r.q)
                2'h0: next_r.sda_rel = 1'b0;
                2'h1: next_r.scl     = 1'b1;
                2'h2: next_r.sda_rel = 1'b1;
                default:
                begin
                  next_r.st      = M_IDLE;
                  next_r.done    = 1'b1;
                  next_r.nack    = r.abort;
                  next_r.rd_data = r.rx;
                  if (r.op == OP_CANCEL || r.op == OP_BUS_RESET || r.abort)
                  begin
                    next_r.addr_unknown = 1'b1;
                  end
                  else if (r.op != OP_READ_CUR)
                  begin
                    next_r.addr_unknown = 1'b0;
                  end
                end
              endcase
            end
            default:
            begin
              // Nine clocks per byte; ninth is the acknowledge slot
              unique case (r.q)
                2'h0: next_r.sda_rel = (r.bitn == `SEB_ACK_SLOT) || sym == SYM_READ || sym == SYM_DUMMY ||
                                       txb[~r.bitn[2:0]];
                2'h1: next_r.scl = 1'b1;
                2'h2:
                begin
                  if (r.bitn != `SEB_ACK_SLOT)
                  begin
                    next_r.rx = {r.rx[6:0], r.sda_st};
                  end
                  else
                  begin
                    next_r.ack_bad = r.sda_st;
                  end
                end
                default:
                begin
                  next_r.scl = 1'b0;
                  if (r.bitn == `SEB_ACK_SLOT)
                  begin
                    next_r.bitn  = '0;
                    next_r.step  = r.step + 3'h1;
                    next_r.abort = r.ack_bad && sym != SYM_READ && sym != SYM_DUMMY;
                  end
                  else
                  begin
                    next_r.bitn = r.bitn + 4'h1;
                  end
                end
              endcase
            end
          endcase
        end
      end
      default:
      begin
        next_r.st = M_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      r <= MST_RST;
    end
    else
    begin
      r <= next_r;
    end
  end

  // Bus clock is driven push-pull; data only pulls low
  assign bus.scl      = r.scl;
  assign bus.sda_m_o  = 1'b0;
  assign bus.sda_m_oe = ~r.sda_rel;
  assign cmd_ready_o  = (r.st == M_IDLE);
  assign done_o       = r.done;
  assign nack_o       = r.nack;
  assign rd_data_o    = r.rd_data;

endmodule : seb_master

/* bench/seb_bus_chk.sv */
// Checker for the link between master and memory device
`timescale 1ns/1ps
module seb_bus_chk #(
  parameter int INIT_CYCLES = 20
)
(
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  // Bus wires
  input wire logic scl,
  input wire logic sda,
  input wire logic sda_s_oe,
  // Device status and pulses
  input wire logic poc_i,
  input wire logic init_done_o,
  input wire logic standby_o,
  input wire logic wr_byte_valid_o,
  input wire logic wr_commit_o
);
  typedef struct packed {
    logic [15:0] n_init;
    logic [3:0]  n_stop;
    logic        has_data;
    logic        sda_q;
    logic        scl_q;
  } seb_chk_s;

  seb_chk_s cur;
  seb_chk_s next_cur;

  // Init length, cycles since stop, data byte since start
  always_comb
  begin
    next_cur = cur;
    next_cur.sda_q = sda;
    next_cur.scl_q = scl;
    next_cur.n_init = (init_done_o || poc_i) ? 16'h0000 : cur.n_init + 16'h0001;
    if (scl && cur.scl_q && cur.sda_q && !sda)
      next_cur.has_data = 1'b0;
    else if (wr_byte_valid_o)
      next_cur.has_data = 1'b1;
    if (scl && cur.scl_q && !cur.sda_q && sda)
      next_cur.n_stop = 4'h0;
    else if (cur.n_stop != 4'hf)
      next_cur.n_stop = cur.n_stop + 4'h1;
  end

  // Saturated stop count at reset, so no stale stop is credited
  always_ff @(posedge clk_sys_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
      cur <= '{n_init: 16'h0000, n_stop: 4'hf, has_data: 1'b0, sda_q: 1'b1, scl_q: 1'b1};
    else
      cur <= next_cur;
  end

  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (sys_rst_i);

  // Bus conditions seen on the system clock
  sequence start_ev;
    scl && $past(scl) && $fell(sda);
  endsequence
  sequence stop_ev;
    scl && $past(scl) && $rose(sda);
  endsequence

  a_init_quiet: assert property (!init_done_o |-> !sda_s_oe && !wr_commit_o && !wr_byte_valid_o)
    else $error("device active while initialising");
  a_init_standby: assert property ($rose(init_done_o) |-> standby_o)
    else $error("initialisation ended without standby");
  a_init_length: assert property ($rose(init_done_o) |-> cur.n_init >= INIT_CYCLES - 1 && cur.n_init <= INIT_CYCLES + 2)
    else $error("initialisation length wrong");
  a_commit_data: assert property (wr_commit_o |-> cur.has_data)
    else $error("write started without a data byte");
  a_commit_stop: assert property (wr_commit_o |-> cur.n_stop <= 4'ha ##1 !wr_commit_o)
    else $error("write started away from a stop");
  a_start_abort: assert property (start_ev |-> !wr_commit_o [*8])
    else $error("write started after a start");
  a_stop_idle: assert property (stop_ev ##0 init_done_o |-> ##[1:12] standby_o)
    else $error("no standby after stop");
  a_drive_scl_low: assert property ($changed(sda_s_oe) |-> !scl)
    else $error("device moved data line with clock high");
endmodule : seb_bus_chk

/* bench/test_serial_eeprom_bus_control.sv */
// Testbench joining master and memory device over the bus
`timescale 1ns/1ps
module test_serial_eeprom_bus_control
  import seb_pkg::*;
;
  localparam int INIT = 20;
  localparam int QTR  = 8;

  logic       clk_sys_i;
  logic       sys_rst_i;
  logic       poc_i;
  logic       poc_fail_i;
  logic [7:0] rd_data_i;
  logic [7:0] rd_addr_o;
  logic       rd_strobe_o;
  int         n_strobe;
  logic       wr_byte_valid_o;
  logic [7:0] wr_addr_o;
  logic [7:0] wr_data_o;
  logic       wr_commit_o;
  logic       standby_o;
  logic       init_done_o;
  logic       cmd_valid_i;
  seb_op_e    cmd_op_i;
  logic [7:0] cmd_addr_i;
  logic [7:0] cmd_data_i;
  logic       cmd_ready_o;
  logic       done_o;
  logic       nack_o;
  logic [7:0] rd_data_o;
  logic [7:0] mem [256];
  int         failures;
  int         n_checks;
  int         n_commit;
  int         n_rise;
  int         n_start;
  int         n_stop;
  int         n_cyc;

  seb_bus_if link();

  seb_slave #(.INIT_CYCLES(INIT)) seb_slave_inst (
    .clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .bus(link), .poc_i(poc_i), .poc_fail_i(poc_fail_i),
    .rd_data_i(rd_data_i), .rd_addr_o(rd_addr_o), .rd_strobe_o(rd_strobe_o), .wr_byte_valid_o(wr_byte_valid_o),
    .wr_addr_o(wr_addr_o), .wr_data_o(wr_data_o), .wr_commit_o(wr_commit_o), .standby_o(standby_o),
    .init_done_o(init_done_o));

  seb_master #(.QUARTER(QTR), .INIT_CYCLES(INIT)) seb_master_inst (
    .clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .bus(link), .cmd_valid_i(cmd_valid_i),
    .cmd_op_i(cmd_op_i), .cmd_addr_i(cmd_addr_i), .cmd_data_i(cmd_data_i), .cmd_ready_o(cmd_ready_o),
    .done_o(done_o), .nack_o(nack_o), .rd_data_o(rd_data_o));

  seb_bus_chk #(.INIT_CYCLES(INIT)) seb_bus_chk_inst (
    .clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .scl(link.scl), .sda(link.sda),
    .sda_s_oe(link.sda_s_oe), .poc_i(poc_i), .init_done_o(init_done_o), .standby_o(standby_o),
    .wr_byte_valid_o(wr_byte_valid_o), .wr_commit_o(wr_commit_o));

  // Array model; only a started write cycle changes it
  assign rd_data_i = mem[rd_addr_o];
  always @(posedge clk_sys_i)
  begin
    if (wr_commit_o === 1'b1)
    begin
      mem[wr_addr_o] <= wr_data_o;
      n_commit++;
    end
  end

  // Wire events, zeroed as each command is sent
  always @(posedge link.scl) n_rise++;
  always @(negedge link.sda) if (link.scl === 1'b1) n_start++;
  always @(posedge link.sda) if (link.scl === 1'b1) n_stop++;
  // Array reads taken by the device, one per single byte read
  always @(posedge clk_sys_i) if (rd_strobe_o === 1'b1) n_strobe++;

  // Clock
  initial
  begin
    clk_sys_i = 1'b0;
    forever #5 clk_sys_i = ~clk_sys_i;
  end

  // Cycle ceiling cuts a hang short
  always @(posedge clk_sys_i)
  begin
    n_cyc++;
    if (n_cyc == 40000)
    begin
      failures++;
      give_verdict();
    end
  end

  task automatic check_bit(input string what, input logic exp, input logic got);
    n_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("ERROR %s expected %b seen %b", what, exp, got);
    end
  endtask : check_bit

  task automatic check_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : check_byte

  // Waits are bounded; a miss shows up in the next compare
  task automatic wait_ready();
    int k;
    k = 0;
    while (cmd_ready_o !== 1'b1 && k < 4000)
    begin
      @(negedge clk_sys_i);
      k++;
    end
  endtask : wait_ready

  // One command: answer, acknowledge and wire counts
  task automatic run_cmd(input seb_op_e op, input logic [7:0] a, input logic [7:0] d,
                         input logic [7:0] rises, input logic [7:0] starts, input logic nk);
    int k;
    wait_ready();
    @(posedge clk_sys_i);
    cmd_valid_i <= 1'b1;
    cmd_op_i <= op;
    cmd_addr_i <= a;
    cmd_data_i <= d;
    n_rise = 0;
    n_start = 0;
    n_stop = 0;
    n_strobe = 0;
    @(posedge clk_sys_i);
    cmd_valid_i <= 1'b0;
    k = 0;
    while (done_o !== 1'b1 && k < 4000)
    begin
      @(negedge clk_sys_i);
      k++;
    end
    check_bit("done", 1'b1, done_o);
    if (nk !== 1'bx)
      check_bit("nack", nk, nack_o);
    check_byte("clock rises", rises, 8'(n_rise));
    check_byte("starts", starts, 8'(n_start));
    check_byte("stops", 8'h01, 8'(n_stop));
    check_byte("read strobes", (op == OP_READ || op == OP_READ_CUR) ? 8'h01 : 8'h00, 8'(n_strobe));
    repeat (8) @(negedge clk_sys_i);
  endtask : run_cmd

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : give_verdict

  // Main sequence
  initial
  begin
    sys_rst_i = 1'b1;
    poc_i = 1'b0;
    poc_fail_i = 1'b0;
    cmd_valid_i = 1'b0;
    cmd_op_i = OP_WRITE;
    cmd_addr_i = 8'h00;
    cmd_data_i = 8'h00;
    for (int i = 0; i < 256; i++)
      mem[i] = ~8'(i);
    repeat (4) @(posedge clk_sys_i);
    sys_rst_i <= 1'b0;
    @(negedge clk_sys_i);
    check_bit("early init", 1'b0, init_done_o);
    wait_ready();
    check_bit("standby", 1'b1, standby_o);
    check_bit("idle clock", 1'b1, link.scl);
    check_bit("idle data", 1'b1, link.sda);
    $display("test power up ended");
    run_cmd(OP_WRITE, 8'h3c, 8'ha5, 8'd28, 8'd1, 1'b0);
    check_byte("commits", 8'd1, 8'(n_commit));
    run_cmd(OP_READ, 8'h3c, 8'h00, 8'd38, 8'd2, 1'b0);
    check_byte("read back", 8'ha5, rd_data_o);
    run_cmd(OP_READ, 8'hff, 8'h00, 8'd38, 8'd2, 1'b0);
    check_byte("top byte", 8'h00, rd_data_o);
    run_cmd(OP_READ_CUR, 8'h00, 8'h00, 8'd19, 8'd1, 1'b0);
    check_byte("wrapped byte", 8'hff, rd_data_o);
    $display("test write and read ended");
    run_cmd(OP_CANCEL, 8'h3c, 8'h77, 8'd20, 8'd2, 1'b0);
    check_byte("commits", 8'd1, 8'(n_commit));
    run_cmd(OP_READ_CUR, 8'h20, 8'h00, 8'd38, 8'd2, 1'b0);
    check_byte("reload read", 8'hdf, rd_data_o);
    run_cmd(OP_READ, 8'h3c, 8'h00, 8'd38, 8'd2, 1'b0);
    check_byte("kept byte", 8'ha5, rd_data_o);
    $display("test cancel ended");
    run_cmd(OP_BUS_RESET, 8'h00, 8'h00, 8'd11, 8'd2, 1'b0);
    check_byte("commits", 8'd1, 8'(n_commit));
    run_cmd(OP_WRITE, 8'h00, 8'h3c, 8'd28, 8'd1, 1'b0);
    check_byte("commits", 8'd2, 8'(n_commit));
    $display("test bus reset ended");
    @(posedge clk_sys_i);
    poc_i <= 1'b1;
    // Clear is registered one edge after it is driven
    repeat (2) @(negedge clk_sys_i);
    check_bit("init restart", 1'b0, init_done_o);
    run_cmd(OP_WRITE, 8'h40, 8'h11, 8'd10, 8'd1, 1'b1);
    check_byte("commits", 8'd2, 8'(n_commit));
    @(posedge clk_sys_i);
    poc_i <= 1'b0;
    repeat (INIT + 8) @(negedge clk_sys_i);
    check_bit("standby again", 1'b1, standby_o);
    run_cmd(OP_READ, 8'h40, 8'h00, 8'd38, 8'd2, 1'b0);
    check_byte("untouched", 8'hbf, rd_data_o);
    $display("test initialisation ended");
    fork
      run_cmd(OP_WRITE, 8'h41, 8'h22, 8'd28, 8'd1, 1'b0);
      begin
        repeat (400) @(posedge clk_sys_i);
        poc_fail_i <= 1'b1;
        poc_i <= 1'b1;
        @(posedge clk_sys_i);
        poc_i <= 1'b0;
        @(negedge clk_sys_i);
        check_bit("init kept", 1'b1, init_done_o);
      end
    join
    @(posedge clk_sys_i);
    poc_fail_i <= 1'b0;
    check_byte("commits", 8'd3, 8'(n_commit));
    $display("test failed clear ended");
    give_verdict();
  end
endmodule : test_serial_eeprom_bus_control
